// ==== design/ipvs_pkg.sv ====
// Package for the interrupt priority and pending vector status block.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
`default_nettype none
package ipvs_pkg;
    localparam int IPVS_NSRC = 8;
    localparam int IPVS_AW = 6;
    localparam logic [5:0] OFF_PRIO17 = 6'h00;
    localparam logic [5:0] OFF_PRIO18 = 6'h04;
    localparam logic [5:0] OFF_PRIO19 = 6'h08;
    localparam logic [5:0] OFF_STATUS = 6'h0c;
    localparam logic [5:0] OFF_FLAGS = 6'h10;
    localparam logic [5:0] OFF_ENABLE = 6'h14;
    localparam logic [5:0] OFF_CPULVL = 6'h18;
    localparam logic [5:0] OFF_TRAP = 6'h1c;
    localparam logic [5:0] OFF_IRQSTAT = 6'h20;
    localparam logic [5:0] OFF_IRQMASK = 6'h24;
    // Field positions of the priority fields (low bit of each).
    localparam int POS_TXREQ = 8;
    localparam int POS_DMA7 = 4;
    localparam int POS_DMA6 = 0;
    localparam int POS_ENC2 = 12;
    localparam int POS_FLT2 = 8;
    localparam int POS_PWM2 = 4;
    localparam int POS_DACL = 12;
    localparam int POS_DACR = 8;
    localparam logic [15:0] MASK_PRIO17 = 16'h0777;
    localparam logic [15:0] MASK_PRIO18 = 16'h7770;
    localparam logic [15:0] MASK_PRIO19 = 16'h7700;
    localparam logic [2:0] PRIO_RESET = 3'h4;
    localparam logic [2:0] PRIO_OFF = 3'h0;
    localparam int POS_LEVEL = 8;
    localparam logic [6:0] VEC_OFFSET = 7'h08;
    localparam logic [3:0] TRAP_LVL_BASE = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Vector numbers of the eight sources, source 7 first in the list.
    localparam logic [7:0][7:0] SRC_VECTOR = {
        8'h55, 8'h54, 8'h53, 8'h52, 8'h51, 8'h50, 8'h4f, 8'h4e};
    typedef enum logic [2:0] {
        IPVS_IDLE = 3'h1,
        IPVS_WAIT = 3'h2,
        IPVS_RESP = 3'h4
    } ipvs_wstate_t;
endpackage
`default_nettype wire

// ==== design/ipvs_select.sv ====
// Priority selector: picks the highest eligible source or trap.
// Assumes inputs are already synchronous to mclk.
`default_nettype none
module ipvs_select
    import ipvs_pkg::*;
(
    // Sources
    input wire logic [ipvs_pkg::IPVS_NSRC*3-1:0] prio,
    input wire logic [ipvs_pkg::IPVS_NSRC-1:0] active,
    input wire logic [3:0] cpuLevel,
    // Traps
    input wire logic [7:0] trapReq,
    // Result
    output logic found,
    output logic [3:0] level,
    output logic [6:0] vecIndex
);
    always_comb
    begin
        found = 1'b0;
        level = 4'h0;
        vecIndex = 7'h00;
        // Lowest index wins ties because only a strictly higher level
        // replaces the current choice.
        for (int i = 0; i < IPVS_NSRC; i++)
        begin
            if (active[i] && prio[i*3 +: 3] != PRIO_OFF
                && {1'b0, prio[i*3 +: 3]} > cpuLevel
                && {1'b0, prio[i*3 +: 3]} > level)
            begin
                found = 1'b1;
                level = {1'b0, prio[i*3 +: 3]};
                vecIndex = SRC_VECTOR[i][6:0] - VEC_OFFSET;
            end
        end
        // Traps ignore the CPU level; trap n sits at level 8+n.
        for (int t = 0; t < 8; t++)
        begin
            if (trapReq[t])
            begin
                found = 1'b1;
                level = TRAP_LVL_BASE + 4'(t);
                vecIndex = 7'(t);
            end
        end
    end
endmodule
`default_nettype wire

// ==== design/ipvs_ctrl.sv ====
// Register file, AXI4-Lite slave and status logic of the priority block.
// Assumes request lines from peripherals asynchronous to mclk; trap lines likewise.
`default_nettype none
// How it works
// - Field value is the priority level directly
// - Zero priority means source disabled
// - Unimplemented bits read zero, ignore writes
// - Register 17: tx request at 10-8
// - Register 17: DMA7 at 6-4, DMA6 at 2-0
// - Register 18: encoder, fault, PWM fields
// - Register 19: DAC left and right fields
// - Status bits 11-8 give new level
// - Status bits 6-0 give vector minus eight
// - Status fields read-only, bits 15-12,7 zero
// - Priority fields reset to level four
// - Traps levels 8-15 never masked; irq trap-seen bit gated by irqMask[1]
module ipvs_ctrl
    import ipvs_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [ipvs_pkg::IPVS_AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    // AXI4-Lite write data
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // AXI4-Lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read address
    input wire logic [ipvs_pkg::IPVS_AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    // AXI4-Lite read data
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Peripheral request pins
    input wire logic [ipvs_pkg::IPVS_NSRC-1:0] srcReq,
    input wire logic [7:0] trapReq,
    // Towards the core
    output logic coreReq,
    output logic [3:0] coreLevel,
    output logic [6:0] coreVector,
    // Interrupt
    output logic irq
);
    logic [15:0] prio17, prio18, prio19, status;
    logic [15:0] next_prio17, next_prio18, next_prio19, next_status;
    logic [7:0] flags, enable, next_flags, next_enable;
    logic [3:0] cpuLevel, next_cpuLevel;
    logic [1:0] irqStat, irqMask, next_irqStat, next_irqMask;
    logic [7:0] reqMeta, reqSync, reqPrev, trapMeta, trapSync;
    logic [IPVS_AW-1:0] wAddr, next_wAddr;
    logic [31:0] wData, next_wData;
    logic [3:0] wStrb, next_wStrb;
    logic haveA, haveD, next_haveA, next_haveD;
    ipvs_wstate_t wState, next_wState;
    logic [1:0] next_bresp;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic next_rvalid;
    logic [IPVS_NSRC*3-1:0] prioVec;
    logic selFound;
    logic [3:0] selLevel;
    logic [6:0] selVec;
    logic doWrite, doRead, statusChange;

    function automatic logic [15:0] merge16(input logic [15:0] old,
        input logic [31:0] data, input logic [3:0] strb,
        input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0])
            v[7:0] = data[7:0];
        if (strb[1])
            v[15:8] = data[15:8];
        return v & mask;
    endfunction

    function automatic logic known(input logic [IPVS_AW-1:0] a);
        return a == OFF_PRIO17 || a == OFF_PRIO18 || a == OFF_PRIO19
            || a == OFF_STATUS || a == OFF_FLAGS || a == OFF_ENABLE
            || a == OFF_CPULVL || a == OFF_TRAP || a == OFF_IRQSTAT
            || a == OFF_IRQMASK;
    endfunction

    // Request pins come from other logic islands, so two stages first.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            reqMeta <= 8'h00;
            reqSync <= 8'h00;
            reqPrev <= 8'h00;
            trapMeta <= 8'h00;
            trapSync <= 8'h00;
        end
        else
        begin
            reqMeta <= srcReq;
            reqSync <= reqMeta;
            reqPrev <= reqSync;
            trapMeta <= trapReq;
            trapSync <= trapMeta;
        end
    end

    assign prioVec = {prio19[POS_DACL +: 3], prio19[POS_DACR +: 3],
        prio18[POS_PWM2 +: 3], prio18[POS_FLT2 +: 3],
        prio18[POS_ENC2 +: 3], prio17[POS_TXREQ +: 3],
        prio17[POS_DMA7 +: 3], prio17[POS_DMA6 +: 3]};

    ipvs_select ipvs_select_i (
        .prio(prioVec),
        .active(flags & enable),
        .cpuLevel(cpuLevel),
        .trapReq(trapSync),
        .found(selFound),
        .level(selLevel),
        .vecIndex(selVec)
    );

    assign doWrite = wState == IPVS_WAIT;
    assign doRead = arvalid && !rvalid;
    assign awready = wState == IPVS_IDLE && !haveA;
    assign wready = wState == IPVS_IDLE && !haveD;
    assign arready = !rvalid;
    assign statusChange = selFound
        && (selLevel != status[11:8] || selVec != status[6:0]);

    always_comb
    begin
        next_wAddr = wAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_haveA = haveA;
        next_haveD = haveD;
        next_wState = wState;
        next_bresp = bresp;
        next_prio17 = prio17;
        next_prio18 = prio18;
        next_prio19 = prio19;
        next_flags = flags | (reqSync & ~reqPrev);
        next_enable = enable;
        next_cpuLevel = cpuLevel;
        next_irqMask = irqMask;
        next_irqStat = irqStat;
        next_status = status;
        unique case (wState)
            IPVS_IDLE:
            begin
                if (awvalid && awready)
                begin
                    next_wAddr = awaddr;
                    next_haveA = 1'b1;
                end
                if (wvalid && wready)
                begin
                    next_wData = wdata;
                    next_wStrb = wstrb;
                    next_haveD = 1'b1;
                end
                if (next_haveA && next_haveD)
                    next_wState = IPVS_WAIT;
            end
            IPVS_WAIT:
            begin
                next_haveA = 1'b0;
                next_haveD = 1'b0;
                next_bresp = known(wAddr) ? RESP_OKAY : RESP_SLVERR;
                next_wState = IPVS_RESP;
                case (wAddr)
                    OFF_PRIO17: next_prio17 =
                        merge16(prio17, wData, wStrb, MASK_PRIO17);
                    OFF_PRIO18: next_prio18 =
                        merge16(prio18, wData, wStrb, MASK_PRIO18);
                    OFF_PRIO19: next_prio19 =
                        merge16(prio19, wData, wStrb, MASK_PRIO19);
                    // Clearing a flag still loses to a new edge.
                    OFF_FLAGS: if (wStrb[0])
                        next_flags = (flags & ~wData[7:0])
                            | (reqSync & ~reqPrev);
                    OFF_ENABLE: if (wStrb[0])
                        next_enable = wData[7:0];
                    OFF_CPULVL: if (wStrb[0])
                        next_cpuLevel = wData[3:0];
                    OFF_IRQMASK: if (wStrb[0])
                        next_irqMask = wData[1:0];
                    default: ;
                endcase
            end
            IPVS_RESP:
                if (bready)
                    next_wState = IPVS_IDLE;
            default: next_wState = IPVS_IDLE;
        endcase
        if (selFound)
        begin
            next_status = 16'h0000;
            next_status[POS_LEVEL +: 4] = selLevel;
            next_status[6:0] = selVec;
        end
        // Sticky events: bit 0 status change, bit 1 trap seen.
        if (doWrite && wAddr == OFF_IRQSTAT && wStrb[0])
            next_irqStat = irqStat & ~wData[1:0];
        next_irqStat = next_irqStat | {|trapSync, statusChange};
    end

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (doRead)
        begin
            next_rvalid = 1'b1;
            next_rresp = known(araddr) ? RESP_OKAY : RESP_SLVERR;
            next_rdata = 32'h0000_0000;
            case (araddr)
                OFF_PRIO17: next_rdata[15:0] = prio17;
                OFF_PRIO18: next_rdata[15:0] = prio18;
                OFF_PRIO19: next_rdata[15:0] = prio19;
                OFF_STATUS: next_rdata[15:0] = status;
                OFF_FLAGS: next_rdata[7:0] = flags;
                OFF_ENABLE: next_rdata[7:0] = enable;
                OFF_CPULVL: next_rdata[3:0] = cpuLevel;
                OFF_TRAP: next_rdata[7:0] = trapSync;
                OFF_IRQSTAT: next_rdata[1:0] = irqStat;
                OFF_IRQMASK: next_rdata[1:0] = irqMask;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            wAddr <= '0;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            haveA <= 1'b0;
            haveD <= 1'b0;
            wState <= IPVS_IDLE;
            bresp <= RESP_OKAY;
            prio17 <= {5'h00, PRIO_RESET, 1'b0, PRIO_RESET, 1'b0,
                PRIO_RESET};
            prio18 <= {1'b0, PRIO_RESET, 1'b0, PRIO_RESET, 1'b0,
                PRIO_RESET, 4'h0};
            prio19 <= {1'b0, PRIO_RESET, 1'b0, PRIO_RESET, 8'h00};
            status <= 16'h0000;
            flags <= 8'h00;
            enable <= 8'h00;
            cpuLevel <= 4'h0;
            irqStat <= 2'h0;
            irqMask <= 2'h0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end
        else
        begin
            wAddr <= next_wAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            haveA <= next_haveA;
            haveD <= next_haveD;
            wState <= next_wState;
            bresp <= next_bresp;
            prio17 <= next_prio17;
            prio18 <= next_prio18;
            prio19 <= next_prio19;
            status <= next_status;
            flags <= next_flags;
            enable <= next_enable;
            cpuLevel <= next_cpuLevel;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    assign bvalid = wState == IPVS_RESP;
    assign coreReq = selFound;
    assign coreLevel = status[11:8];
    assign coreVector = status[6:0];
    assign irq = |(irqStat & irqMask);
endmodule
`default_nettype wire

// ==== verification/ipvs_props.sv ====
// Checker for the priority block, watching only its top-level ports.
// Assumes the single clock mclk and the asynchronous reset rst.
`default_nettype none
module ipvs_props (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Bus handshakes
    input wire logic awready,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    input wire logic rready,
    // Requests and status
    input wire logic [7:0] trapReq,
    input wire logic coreReq,
    input wire logic [3:0] coreLevel,
    input wire logic [6:0] coreVector
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered next cycle");
    a_read_once: assert property (rvalid && rready |=> !rvalid)
        else $error("read data stayed after acceptance");
    a_arready_busy: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    a_write_busy: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    a_bvalid_once: assert property (bvalid && bready |=> !bvalid)
        else $error("write response stayed after acceptance");
    a_status_reset: assert property ($past(rst) |->
        coreLevel == 4'h0 && coreVector == 7'h00)
        else $error("status not cleared by reset");
    a_status_hold: assert property (!coreReq |=>
        $stable({coreLevel, coreVector}))
        else $error("status moved with no eligible request");
    // A trap held three cycles clears the two-stage synchroniser.
    a_trap_top: assert property (trapReq[7] [*3] |->
        coreReq ##1 (coreLevel == 4'hf && coreVector == 7'h07))
        else $error("top trap not reported at level fifteen");
    c_read: cover property (rvalid && rready);
    c_write: cover property (bvalid && bready);
    c_trap: cover property (trapReq[7] && coreReq);
endmodule
bind ipvs_ctrl ipvs_props ipvs_props_i (.*);
`default_nettype wire

// ==== verification/ipvs_src_model.sv ====
// Peripheral and trap request sources standing beside the block.
// Assumes bench commands change just after mclk rising edges.
`default_nettype none
module ipvs_src_model (
    // Clock and commands
    input wire logic mclk,
    input wire logic [7:0] fireSrc,
    input wire logic [7:0] holdTrap,
    // Request lines
    output logic [7:0] srcReq,
    output logic [7:0] trapReq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] stage1 = 8'h00;
    logic [7:0] stage2 = 8'h00;
    logic [7:0] stage3 = 8'h00;
    // A request stays up three cycles so the synchroniser cannot miss it.
    always_ff @(posedge mclk)
    begin
        stage1 <= fireSrc;
        stage2 <= stage1;
        stage3 <= stage2;
    end
    assign srcReq = stage1 | stage2 | stage3;
    assign trapReq = holdTrap;
endmodule
`default_nettype wire

// ==== verification/irq_priority_and_vector_status_tb.sv ====
// Self-checking bench for the priority and pending vector block.
// Assumes the bus slave answers in its own time on a 10 MHz mclk.
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
    err_count++; $display("BAD %0t got %h want %h", $time, a, e); end end
module irq_priority_and_vector_status_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ipvs_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [5:0] awaddr = 6'h00;
    logic [5:0] araddr = 6'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b1;
    logic rready = 1'b1;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic [7:0] fireSrc = 8'h00;
    logic [7:0] holdTrap = 8'h00;
    logic awready, wready, bvalid, arready, rvalid, coreReq, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, d;
    logic [7:0] srcReq, trapReq;
    logic [3:0] coreLevel;
    logic [6:0] coreVector;
    logic [15:0] msk [3] = '{16'h0777, 16'h7770, 16'h7700};
    logic [33:0] rq [$];
    logic [1:0] bq [$];
    int err_count = 0;
    int comparisons = 0;

    ipvs_ctrl ipvs_ctrl_i (.*);
    ipvs_src_model ipvs_src_model_i (.*);

    initial
    begin
        forever #50 mclk = ~mclk;
    end

    // Responses are compared in the cycle the bus accepts them.
    always @(posedge mclk)
    begin
        if (rvalid && rready) `CHK({rresp, rdata}, rq.pop_front())
        if (bvalid && bready) `CHK(bresp, bq.pop_front())
    end

    task automatic wr(input logic [5:0] a, input logic [31:0] v,
        input logic [1:0] r);
        logic aw, w;
        bq.push_back(r);
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge mclk);
            aw |= awready;
            w |= wready;
            awvalid <= !aw;
            wvalid <= !w;
        end
        do @(posedge mclk); while (!bvalid);
    endtask

    task automatic rd(input logic [5:0] a, input logic [31:0] v);
        rq.push_back({RESP_OKAY, v});
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge mclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge mclk); while (!rvalid);
    endtask

    // Sources need time to pass the synchroniser before status is read.
    task automatic fire(input logic [7:0] v);
        fireSrc <= v;
        @(posedge mclk);
        fireSrc <= 8'h00;
        repeat (8) @(posedge mclk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'haed0596e));
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(OFF_PRIO17, 32'h0444);
        rd(OFF_PRIO18, 32'h4440);
        rd(OFF_PRIO19, 32'h4400);
        rd(OFF_STATUS, 32'h0);
        $display("reset values done");
        for (int i = 0; i < 3; i++)
        begin
            wr(6'(4 * i), 32'hffffffff, RESP_OKAY);
            rd(6'(4 * i), {16'h0000, msk[i]});
            d = $urandom;
            wr(6'(4 * i), d, RESP_OKAY);
            rd(6'(4 * i), {16'h0000, d[15:0] & msk[i]});
        end
        wr(OFF_STATUS, 32'hffffffff, RESP_OKAY);
        rd(OFF_STATUS, 32'h0);
        wr(6'h3c, 32'h1, RESP_SLVERR);
        $display("register map done");
        wr(OFF_PRIO17, 32'h0350, RESP_OKAY);
        wr(OFF_ENABLE, 32'hff, RESP_OKAY);
        wr(OFF_IRQMASK, 32'h0, RESP_OKAY);
        fire(8'h01);
        rd(OFF_STATUS, 32'h0);
        wr(OFF_CPULVL, 32'h5, RESP_OKAY);
        fire(8'h06);
        rd(OFF_STATUS, 32'h0);
        `CHK(coreReq, 1'b0)
        wr(OFF_CPULVL, 32'h2, RESP_OKAY);
        rd(OFF_STATUS, 32'h0547);
        `CHK({coreLevel, coreVector}, {4'h5, 7'h47})
        `CHK(irq, 1'b0)
        wr(OFF_IRQMASK, 32'h1, RESP_OKAY);
        `CHK(irq, 1'b1)
        wr(OFF_FLAGS, 32'hff, RESP_OKAY);
        wr(OFF_IRQSTAT, 32'h3, RESP_OKAY);
        `CHK(irq, 1'b0)
        $display("selection and interrupt done");
        wr(OFF_CPULVL, 32'hf, RESP_OKAY);
        holdTrap <= 8'h88;
        for (int k = 0; k < 20 && !coreReq; k++) @(posedge mclk);
        rd(OFF_STATUS, 32'h0f07);
        `CHK({coreLevel, coreVector}, {4'hf, 7'h07})
        holdTrap <= 8'h00;
        $display("trap done");
        give_verdict();
    end
endmodule
`default_nettype wire
